//--- design/menu_pkg.sv
/*
 * Shared constants and types of the magnet switch menu controller:
 * timing in milliseconds, register offsets, loop current levels,
 * menu states, display message codes and the switch event carrier.
 * Assumes a 40 MHz reference clock and a 1 ms internal tick.
 */
package menu_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // clock and tick
    localparam int unsigned CLK_HZ       = 40_000_000;
    localparam int unsigned TICK_US      = 1000;
    localparam int unsigned TICK_CYC_DEF = CLK_HZ / 1_000_000 * TICK_US;

    ////////////////////////////////////////////////////////////////////////////
    // times in milliseconds, one tick each
    localparam int MSW = 17;
    localparam logic [MSW-1:0] HOLD_SHORT_MS   = 17'h00BB8;  // 3 s
    localparam logic [MSW-1:0] HOLD_LONG_MS    = 17'h02710;  // 10 s
    localparam logic [MSW-1:0] EDIT_TIMEOUT_MS = 17'h00DAC;  // 3.5 s
    localparam logic [MSW-1:0] CAL_TIMEOUT_MS  = 17'h01388;  // 5 s
    localparam logic [MSW-1:0] MINUTE_MS       = 17'h0EA60;  // 60 s
    localparam logic [MSW-1:0] FAULT_FLASH_MS  = 17'h07530;  // 30 s
    localparam logic [MSW-1:0] FLASH_MS        = 17'h003E8;  // 1 s
    localparam logic [MSW-1:0] SCROLL_MS       = 17'h007D0;  // 2 s
    localparam logic [MSW-1:0] MS_ONE          = 17'h00001;

    ////////////////////////////////////////////////////////////////////////////
    // menu sizes
    localparam logic [2:0] ITEM_STATUS      = 3'h0;
    localparam logic [2:0] ITEM_OUT_CHECK   = 3'h6;
    localparam logic [2:0] ITEM_LAST        = 3'h7;
    localparam logic [3:0] STATUS_LAST      = 4'hD;
    localparam logic [2:0] PGM_IDLE_SCROLLS = 3'h4;
    localparam logic [2:0] ZERO_SCROLLS     = 3'h6;
    localparam logic [2:0] SPAN_SCROLLS     = 3'h2;

    ////////////////////////////////////////////////////////////////////////////
    // loop current in microamps, reading as fraction of full scale
    localparam int CONC_W = 12;
    localparam logic [15:0] LOOP_ZERO_UA = 16'h0FA0;  // 4 mA
    localparam logic [15:0] LOOP_SPAN_UA = 16'h3E80;  // 16 mA span
    localparam logic [15:0] LOOP_CAL_UA  = 16'h07D0;  // 2 mA
    localparam int CAL_STATUS_BIT = 14;

    ////////////////////////////////////////////////////////////////////////////
    // apb register offsets
    localparam logic [7:0] REG_CONC   = 8'h00;
    localparam logic [7:0] REG_FAULT  = 8'h04;
    localparam logic [7:0] REG_STATE  = 8'h08;
    localparam logic [7:0] REG_VALUE  = 8'h0C;
    localparam logic [7:0] REG_LOOP   = 8'h10;

    ////////////////////////////////////////////////////////////////////////////
    // types
    typedef enum logic [6:0] {
        ST_NORMAL = 7'h01,
        ST_FAULTS = 7'h02,
        ST_CALP   = 7'h04,
        ST_ZERO   = 7'h08,
        ST_SPAN   = 7'h10,
        ST_PSCR   = 7'h20,
        ST_EDIT   = 7'h40
    } state_t;

    typedef enum logic [3:0] {
        MSG_READING    = 4'h0,
        MSG_UNITS_GAS  = 4'h1,
        MSG_FAULT_DET  = 4'h2,
        MSG_FAULT_LIST = 4'h3,
        MSG_CAL_PROMPT = 4'h4,
        MSG_ZERO_START = 4'h5,
        MSG_ZERO_SET   = 4'h6,
        MSG_ZERO_SAVED = 4'h7,
        MSG_SPAN_START = 4'h8,
        MSG_PGM_ITEM   = 4'h9,
        MSG_EDIT_VALUE = 4'hA
    } msg_t;

    typedef struct packed {
        logic active;
        logic touch;
        logic hold3;
        logic hold10;
    } sw_evt_t;

endpackage

//--- design/magnet_switch_sense.sv
/*
 * Classifies one magnet switch into active level, momentary touch,
 * 3 s hold and 10 s hold. Assumes a switch level synchronous to the
 * clock and a one-cycle tick each millisecond.
 */
`timescale 1ns/1ps
module magnet_switch_sense (
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    input  wire logic             tick_i,
    input  wire logic             sw_i,
    output menu_pkg::sw_evt_t     evt_o
);
    import menu_pkg::*;

    logic            held_ff;
    logic [MSW-1:0]  cnt_ff;
    sw_evt_t         evt_ff;
    logic [MSW-1:0]  nxt_cnt;
    sw_evt_t         nxt_evt;

    assign nxt_cnt = !sw_i ? '0 :
                     (tick_i && cnt_ff != HOLD_LONG_MS) ? cnt_ff + MS_ONE : cnt_ff;

    assign nxt_evt.active = sw_i;
    assign nxt_evt.touch  = held_ff && !sw_i && cnt_ff < HOLD_SHORT_MS;
    assign nxt_evt.hold3  = sw_i && tick_i && cnt_ff == HOLD_SHORT_MS - MS_ONE;
    assign nxt_evt.hold10 = sw_i && tick_i && cnt_ff == HOLD_LONG_MS - MS_ONE;

    assign evt_o = evt_ff;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            held_ff <= 1'b0;
            cnt_ff  <= '0;
            evt_ff  <= '0;
        end else begin
            held_ff <= sw_i;
            cnt_ff  <= nxt_cnt;
            evt_ff  <= nxt_evt;
        end
    end

endmodule

//--- design/menu_ctrl.sv
/*
 * Operator menu controller of a gas transmitter: two magnet switches,
 * display message selection, loop current level, 16-bit parallel status word,
 * and an APB slave for reading input, fault bits and state readback.
 * Assumes switch levels synchronous to REF_CLK_I and an APB master.
 */
`timescale 1ns/1ps
// Behaviour
// - classify touch, 3 s and 10 s holds
// - holds enter menus, touches step values
// - arrow shown while switch active
// - four idle scrolls leave program mode
// - edit idle 3.5 s returns to scroll, except on the output check item
// - flash units and gas every minute
// - flash fault message once per minute
// - touch during fault shows fault list
// - loop current tracks concentration
// - reading and faults always current
// - left 3 s hold enters calibration
// - left hold zeroes, 5 s timeout
// - calibration forces 2 mA, status bit
// - three zero messages, two scrolls each
// - three major modes only
// - status view walks fourteen entries
// - program items in fixed order
// - right 10 s hold enters program mode
// - right 3 s hold starts span
module menu_ctrl #(
    parameter int unsigned TICK_CYC = menu_pkg::TICK_CYC_DEF
) (
    input  wire logic                      REF_CLK_I,
    input  wire logic                      RST_N_I,
    input  wire logic                      PSEL_I,
    input  wire logic                      PENABLE_I,
    input  wire logic                      PWRITE_I,
    input  wire logic [7:0]                PADDR_I,
    input  wire logic [31:0]               PWDATA_I,
    output logic      [31:0]               PRDATA_O,
    output logic                           PREADY_O,
    output logic                           PSLVERR_O,
    input  wire logic                      LEFT_MAGNET_SWITCH_I,
    input  wire logic                      RIGHT_MAGNET_SWITCH_I,
    output logic                           ARROW_LEFT_O,
    output logic                           ARROW_RIGHT_O,
    output menu_pkg::msg_t                 DISPLAY_MSG_O,
    output logic      [3:0]                DISPLAY_ITEM_O,
    output logic      [15:0]               LOOP_UA_O,
    output logic      [menu_pkg::CONC_W-1:0] READING_O,
    output logic      [15:0]               STATUS_WORD_O,
    output logic                           ZERO_REQ_O,
    output logic                           SPAN_REQ_O
);
    import menu_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // millisecond tick

    logic [31:0] div_ff;
    logic        tick_ff;
    wire         div_end = (div_ff == TICK_CYC - 1);

    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            div_ff  <= '0;
            tick_ff <= 1'b0;
        end else begin
            div_ff  <= div_end ? '0 : div_ff + 32'h0000_0001;
            tick_ff <= div_end;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // switch classifiers

    sw_evt_t lft;
    sw_evt_t rgt;

    magnet_switch_sense u_left (
        .clk_i   (REF_CLK_I),
        .rst_n_i (RST_N_I),
        .tick_i  (tick_ff),
        .sw_i    (LEFT_MAGNET_SWITCH_I),
        .evt_o   (lft)
    );

    magnet_switch_sense u_right (
        .clk_i   (REF_CLK_I),
        .rst_n_i (RST_N_I),
        .tick_i  (tick_ff),
        .sw_i    (RIGHT_MAGNET_SWITCH_I),
        .evt_o   (rgt)
    );

    ////////////////////////////////////////////////////////////////////////////
    // apb slave, no wait states: data registered in the setup cycle

    logic [CONC_W-1:0] conc_ff;
    logic [7:0]        fault_ff;
    logic [31:0]       prdata_ff;
    logic              pready_ff;
    logic              pslverr_ff;
    logic [7:0]        value_ff;
    logic [7:0]        saved_ff;
    logic [15:0]       loop_ff;
    state_t            state_ff;
    logic [2:0]        item_ff;
    logic [3:0]        sub_ff;
    msg_t              msg_ff;

    wire setup    = PSEL_I && !PENABLE_I;
    wire wr_acc   = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I && !PSLVERR_O;
    wire hit_conc = (PADDR_I == REG_CONC);
    wire hit_flt  = (PADDR_I == REG_FAULT);
    wire hit_st   = (PADDR_I == REG_STATE);
    wire hit_val  = (PADDR_I == REG_VALUE);
    wire hit_loop = (PADDR_I == REG_LOOP);
    wire mapped   = hit_conc || hit_flt || hit_st || hit_val || hit_loop;
    wire ro_write = PWRITE_I && (hit_st || hit_val || hit_loop);

    wire [31:0] rd_mux =
        hit_conc ? {{(32-CONC_W){1'b0}}, conc_ff} :
        hit_flt  ? {24'h00_0000, fault_ff} :
        hit_st   ? {12'h000, msg_ff, sub_ff, 1'b0, item_ff, 1'b0, state_ff} :
        hit_val  ? {16'h0000, saved_ff, value_ff} :
        hit_loop ? {16'h0000, loop_ff} : 32'h0000_0000;

    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= '0;
            conc_ff    <= '0;
            fault_ff   <= '0;
        end else begin
            pready_ff  <= setup;
            pslverr_ff <= setup && (!mapped || ro_write);
            prdata_ff  <= (setup && !PWRITE_I && mapped) ? rd_mux : 32'h0000_0000;
            if (wr_acc && hit_conc) begin
                conc_ff <= PWDATA_I[CONC_W-1:0];
            end
            if (wr_acc && hit_flt) begin
                fault_ff <= PWDATA_I[7:0];
            end
        end
    end

    assign PRDATA_O  = prdata_ff;
    assign PREADY_O  = pready_ff;
    assign PSLVERR_O = pslverr_ff;

    ////////////////////////////////////////////////////////////////////////////
    // menu state machine

    logic [MSW-1:0] tmr_ff;
    logic [MSW-1:0] min_ff;
    logic [2:0]     scr_ff;
    logic           zreq_ff;
    logic           sreq_ff;

    state_t         nxt_state;
    logic [MSW-1:0] nxt_tmr;
    logic [2:0]     nxt_item;
    logic [3:0]     nxt_sub;
    logic [2:0]     nxt_scr;
    logic [7:0]     nxt_value;
    logic [7:0]     nxt_saved;
    msg_t           nxt_msg;

    wire fault_on    = |fault_ff;
    wire any_touch   = lft.touch || rgt.touch;
    wire any_hold3   = lft.hold3 || rgt.hold3;
    wire any_act     = lft.active || rgt.active;
    wire scroll_done = tick_ff && (tmr_ff == SCROLL_MS - MS_ONE);
    wire [MSW-1:0] tmr_inc = tick_ff ? tmr_ff + MS_ONE : tmr_ff;
    wire [MSW-1:0] min_inc = !tick_ff ? min_ff :
                             (min_ff == MINUTE_MS - MS_ONE) ? '0 : min_ff + MS_ONE;
    wire in_cal = (state_ff == ST_CALP) || (state_ff == ST_ZERO) || (state_ff == ST_SPAN);

    wire units_win = (min_ff < FLASH_MS);
    wire fault_win = fault_on && (min_ff >= FAULT_FLASH_MS) &&
                     (min_ff < FAULT_FLASH_MS + FLASH_MS);

    // only normal, calibration and program modes
    always_comb begin
        nxt_state = state_ff;
        nxt_tmr   = tmr_inc;
        nxt_item  = item_ff;
        nxt_sub   = sub_ff;
        nxt_scr   = scr_ff;
        nxt_value = value_ff;
        nxt_saved = saved_ff;
        nxt_msg   = msg_ff;
        case (state_ff)
            ST_NORMAL: begin
                nxt_msg = units_win ? MSG_UNITS_GAS :
                          fault_win ? MSG_FAULT_DET : MSG_READING;
                if (lft.hold3) begin
                    nxt_state = ST_CALP;
                    nxt_tmr   = '0;
                    nxt_msg   = MSG_CAL_PROMPT;
                end else if (rgt.hold10) begin
                    nxt_state = ST_PSCR;
                    nxt_tmr   = '0;
                    nxt_item  = ITEM_STATUS;
                    nxt_sub   = '0;
                    nxt_scr   = '0;
                    nxt_msg   = MSG_PGM_ITEM;
                end else if (fault_on && any_touch) begin
                    nxt_state = ST_FAULTS;
                    nxt_tmr   = '0;
                    nxt_msg   = MSG_FAULT_LIST;
                end
            end
            ST_FAULTS: begin
                if (scroll_done) begin
                    nxt_state = ST_NORMAL;
                    nxt_msg   = MSG_READING;
                end
            end
            ST_CALP: begin
                if (lft.hold3) begin
                    nxt_state = ST_ZERO;
                    nxt_tmr   = '0;
                    nxt_scr   = '0;
                    nxt_msg   = MSG_ZERO_START;
                end else if (rgt.hold3) begin
                    nxt_state = ST_SPAN;
                    nxt_tmr   = '0;
                    nxt_scr   = '0;
                    nxt_msg   = MSG_SPAN_START;
                end else if (tick_ff && tmr_ff == CAL_TIMEOUT_MS - MS_ONE) begin
                    nxt_state = ST_NORMAL;
                    nxt_msg   = MSG_READING;
                end
            end
            ST_ZERO: begin
                if (scroll_done) begin
                    nxt_tmr = '0;
                    nxt_scr = scr_ff + 3'h1;
                    if (scr_ff == ZERO_SCROLLS - 3'h1) begin
                        nxt_state = ST_NORMAL;
                        nxt_msg   = MSG_READING;
                    end else begin
                        case (nxt_scr[2:1])
                            2'h0:    nxt_msg = MSG_ZERO_START;
                            2'h1:    nxt_msg = MSG_ZERO_SET;
                            default: nxt_msg = MSG_ZERO_SAVED;
                        endcase
                    end
                end
            end
            ST_SPAN: begin
                if (scroll_done) begin
                    nxt_tmr = '0;
                    nxt_scr = scr_ff + 3'h1;
                    if (scr_ff == SPAN_SCROLLS - 3'h1) begin
                        nxt_state = ST_NORMAL;
                        nxt_msg   = MSG_READING;
                    end
                end
            end
            ST_PSCR: begin
                nxt_msg = MSG_PGM_ITEM;
                if (any_touch) begin
                    // step through the fixed item order
                    nxt_item = lft.touch ? item_ff - 3'h1 : item_ff + 3'h1;
                    nxt_sub  = '0;
                    nxt_scr  = '0;
                    nxt_tmr  = '0;
                end else if (any_hold3 && item_ff != ITEM_STATUS) begin
                    // hold opens the item for editing, except the status item
                    nxt_state = ST_EDIT;
                    nxt_tmr   = '0;
                    nxt_value = saved_ff;
                    nxt_msg   = MSG_EDIT_VALUE;
                end else if (any_act) begin
                    nxt_scr = '0;
                end else if (scroll_done) begin
                    nxt_tmr = '0;
                    if (item_ff == ITEM_STATUS) begin
                        nxt_sub = (sub_ff == STATUS_LAST) ? 4'h0 : sub_ff + 4'h1;
                    end
                    nxt_scr = scr_ff + 3'h1;
                    if (scr_ff == PGM_IDLE_SCROLLS - 3'h1) begin
                        nxt_state = ST_NORMAL;
                        nxt_msg   = MSG_READING;
                    end
                end
            end
            ST_EDIT: begin
                if (any_touch) begin
                    nxt_value = lft.touch ? value_ff - 8'h01 : value_ff + 8'h01;
                    nxt_tmr   = '0;
                end else if (any_hold3) begin
                    nxt_saved = value_ff;
                    nxt_state = ST_PSCR;
                    nxt_tmr   = '0;
                    nxt_scr   = '0;
                    nxt_msg   = MSG_PGM_ITEM;
                end else if (any_act) begin
                    nxt_tmr = '0;
                end else if (tick_ff && tmr_ff == EDIT_TIMEOUT_MS - MS_ONE &&
                             item_ff != ITEM_OUT_CHECK) begin
                    nxt_state = ST_PSCR;
                    nxt_tmr   = '0;
                    nxt_scr   = '0;
                    nxt_msg   = MSG_PGM_ITEM;
                end
            end
            default: begin
                nxt_state = ST_NORMAL;
                nxt_tmr   = '0;
                nxt_msg   = MSG_READING;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // loop current

    wire [27:0] span_prod = conc_ff * LOOP_SPAN_UA;
    // 4 mA plus share of span
    wire [15:0] loop_norm = LOOP_ZERO_UA + span_prod[27:12];
    wire [15:0] nxt_loop  = in_cal ? LOOP_CAL_UA : loop_norm;

    ////////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            state_ff <= ST_NORMAL;
            tmr_ff   <= '0;
            min_ff   <= '0;
            item_ff  <= '0;
            sub_ff   <= '0;
            scr_ff   <= '0;
            value_ff <= '0;
            saved_ff <= '0;
            msg_ff   <= MSG_READING;
            loop_ff  <= LOOP_ZERO_UA;
            zreq_ff  <= 1'b0;
            sreq_ff  <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            tmr_ff   <= nxt_tmr;
            min_ff   <= min_inc;
            item_ff  <= nxt_item;
            sub_ff   <= nxt_sub;
            scr_ff   <= nxt_scr;
            value_ff <= nxt_value;
            saved_ff <= nxt_saved;
            msg_ff   <= nxt_msg;
            loop_ff  <= nxt_loop;
            zreq_ff  <= (state_ff == ST_CALP) && (nxt_state == ST_ZERO);
            sreq_ff  <= (state_ff == ST_CALP) && (nxt_state == ST_SPAN);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin outputs

    logic              arr_l_ff;
    logic              arr_r_ff;
    logic [15:0]       status_ff;
    logic [CONC_W-1:0] reading_ff;
    logic [3:0]        disp_item_ff;

    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            arr_l_ff   <= 1'b0;
            arr_r_ff   <= 1'b0;
            status_ff  <= '0;
            reading_ff <= '0;
            disp_item_ff <= '0;
        end else begin
            arr_l_ff   <= lft.active;
            arr_r_ff   <= rgt.active;
            status_ff  <= {1'b0, in_cal, 6'h00, fault_ff};
            reading_ff <= conc_ff;
            disp_item_ff <= (nxt_state == ST_PSCR && nxt_item == ITEM_STATUS) ? nxt_sub :
                            {1'b0, nxt_item};
        end
    end

    assign ARROW_LEFT_O   = arr_l_ff;
    assign ARROW_RIGHT_O  = arr_r_ff;
    assign DISPLAY_MSG_O  = msg_ff;
    assign DISPLAY_ITEM_O = disp_item_ff;
    assign LOOP_UA_O      = loop_ff;
    assign READING_O      = reading_ff;
    assign STATUS_WORD_O  = status_ff;
    assign ZERO_REQ_O     = zreq_ff;
    assign SPAN_REQ_O     = sreq_ff;

endmodule

//--- verif/menu_ctrl_monitor.sv
/* port checker of menu_ctrl; assumes one clock and active-low async reset */
`timescale 1ns/1ps
module menu_ctrl_monitor (
    input  wire logic           REF_CLK_I,
    input  wire logic           RST_N_I,
    input  wire logic           PSEL_I,
    input  wire logic           PENABLE_I,
    input  wire logic           PREADY_O,
    input  wire logic           LEFT_MAGNET_SWITCH_I,
    input  wire logic           RIGHT_MAGNET_SWITCH_I,
    input  wire logic           ARROW_LEFT_O,
    input  wire logic           ARROW_RIGHT_O,
    input  wire menu_pkg::msg_t DISPLAY_MSG_O,
    input  wire logic [15:0]    LOOP_UA_O,
    input  wire logic [11:0]    READING_O,
    input  wire logic [15:0]    STATUS_WORD_O,
    input  wire logic           ZERO_REQ_O,
    input  wire logic           SPAN_REQ_O
);
    import menu_pkg::*;
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (!RST_N_I);
    AST_ARROW_LEFT_ON: assert property (LEFT_MAGNET_SWITCH_I[*5] |-> ARROW_LEFT_O)
        else $error("left arrow not shown");
    AST_ARROW_RIGHT_ON: assert property (RIGHT_MAGNET_SWITCH_I[*5] |-> ARROW_RIGHT_O)
        else $error("right arrow not shown");
    AST_ARROW_LEFT_OFF: assert property ((!LEFT_MAGNET_SWITCH_I)[*5] |-> !ARROW_LEFT_O)
        else $error("left arrow stuck");
    AST_LOOP_TRACK: assert property (($stable(READING_O) && !STATUS_WORD_O[14])[*3] |->
        LOOP_UA_O == 16'(32'(LOOP_ZERO_UA) + ((32'(READING_O) * 32'(LOOP_SPAN_UA)) >> 12)))
        else $error("loop current off");
    AST_CAL_LOOP: assert property (STATUS_WORD_O[14][*3] |-> LOOP_UA_O == LOOP_CAL_UA)
        else $error("loop not forced in calibration");
    AST_CAL_MSG: assert property ($rose(STATUS_WORD_O[14]) |->
        ##[0:2] DISPLAY_MSG_O == MSG_CAL_PROMPT)
        else $error("calibration prompt missing");
    AST_ZERO_IN_CAL: assert property (ZERO_REQ_O |-> STATUS_WORD_O[14])
        else $error("zeroing outside calibration");
    AST_ZERO_MSG: assert property ($rose(ZERO_REQ_O) |-> ##[0:3] DISPLAY_MSG_O == MSG_ZERO_START)
        else $error("zero start message missing");
    AST_SPAN_START: assert property (SPAN_REQ_O |-> STATUS_WORD_O[14] &&
        DISPLAY_MSG_O == MSG_SPAN_START)
        else $error("span start not flagged");
    AST_APB_READY: assert property (PREADY_O |-> PSEL_I && PENABLE_I)
        else $error("ready outside access");
endmodule
bind menu_ctrl menu_ctrl_monitor menu_ctrl_monitor_inst (.REF_CLK_I, .RST_N_I, .PSEL_I,
    .PENABLE_I, .PREADY_O, .LEFT_MAGNET_SWITCH_I, .RIGHT_MAGNET_SWITCH_I, .ARROW_LEFT_O,
    .ARROW_RIGHT_O, .DISPLAY_MSG_O, .LOOP_UA_O, .READING_O, .STATUS_WORD_O, .ZERO_REQ_O,
    .SPAN_REQ_O);

//--- verif/magnet_operator.sv
/* operator holding a magnet over one switch; assumes bench clock */
`timescale 1ns/1ps
module magnet_operator (
    input  wire logic clk_i,
    output logic      left_o,
    output logic      right_o
);
    initial {left_o, right_o} = 2'b00;
    task automatic press(input bit rgt, input int cyc);
        @(posedge clk_i);
        {left_o, right_o} <= rgt ? 2'b01 : 2'b10;
        repeat (cyc) @(posedge clk_i);
        {left_o, right_o} <= 2'b00;
    endtask
endmodule

//--- verif/magnet_switch_menu_controller_bench.sv
/* bench of menu_ctrl; operator model drives magnets, apb tasks drive registers */
`timescale 1ns/1ps
module magnet_switch_menu_controller_bench;
    import menu_pkg::*;
    localparam int TC    = 1;
    localparam int HOLD  = int'(HOLD_SHORT_MS) * TC + 40;
    localparam int HOLDL = int'(HOLD_LONG_MS) * TC + 40;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, err, left, right;
    msg_t        msg;
    logic [15:0] loop, status;
    logic [11:0] reading;
    logic [3:0]  item;
    int          n_errors = 0;
    int          n_tests = 0;
    int          cyc = 0;
    int          conc_q[$];
    menu_ctrl #(.TICK_CYC(TC)) menu_ctrl_inst (.REF_CLK_I(clk), .RST_N_I(rst_n),
        .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
        .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
        .LEFT_MAGNET_SWITCH_I(left), .RIGHT_MAGNET_SWITCH_I(right), .ARROW_LEFT_O(),
        .ARROW_RIGHT_O(), .DISPLAY_MSG_O(msg), .DISPLAY_ITEM_O(item), .LOOP_UA_O(loop),
        .READING_O(reading), .STATUS_WORD_O(status), .ZERO_REQ_O(), .SPAN_REQ_O());
    magnet_operator magnet_operator_inst (.clk_i(clk), .left_o(left), .right_o(right));
    initial forever #12.5 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 70000) begin
            n_errors++;
            results();
        end
    end
    task automatic results();
        $display("checks %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic check(string what, logic [31:0] exp, logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(bit wr, logic [7:0] a, logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_ms(int n);
        repeat (n * TC) @(posedge clk);
    endtask
    function automatic int exp_loop(int c);
        return int'(LOOP_ZERO_UA) + ((c * int'(LOOP_SPAN_UA)) >> 12);
    endfunction
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        int n;
        n = $urandom(31);
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        wait_ms(500);
        check("msg", MSG_UNITS_GAS, msg);
        $display("test flash done");
        repeat (3) conc_q.push_back($urandom % 4096);
        foreach (conc_q[i]) begin
            apb(1'b1, REG_CONC, conc_q[i]);
            apb(1'b0, REG_CONC, 32'h0);
            check("conc", conc_q[i], rd);
            check("reading", conc_q[i], reading);
            apb(1'b0, REG_LOOP, 32'h0);
            check("loop reg", exp_loop(conc_q[i]), rd);
            check("loop", exp_loop(conc_q[i]), loop);
        end
        apb(1'b0, 8'h14, 32'h0);
        check("unmapped err", 32'h1, err);
        check("unmapped data", 32'h0, rd);
        apb(1'b1, REG_LOOP, 32'h1);
        check("read-only err", 32'h1, err);
        $display("test registers done");
        wait_ms(600);
        magnet_operator_inst.press(1'b1, 400);
        repeat (20) @(posedge clk);
        check("msg", MSG_READING, msg);
        apb(1'b1, REG_FAULT, 32'h1);
        repeat (2) @(posedge clk);
        check("status", 32'h1, status);
        magnet_operator_inst.press(1'b0, 400);
        repeat (20) @(posedge clk);
        check("msg", MSG_FAULT_LIST, msg);
        apb(1'b1, REG_FAULT, 32'h0);
        wait_ms(2100);
        $display("test touch done");
        magnet_operator_inst.press(1'b0, HOLD);
        repeat (8) @(posedge clk);
        check("msg", MSG_CAL_PROMPT, msg);
        check("loop", LOOP_CAL_UA, loop);
        check("cal flag", 32'h1, status[14]);
        wait_ms(4900);
        check("msg", MSG_CAL_PROMPT, msg);
        wait_ms(200);
        check("msg", MSG_READING, msg);
        check("cal flag", 32'h0, status[14]);
        $display("test calibration done");
        magnet_operator_inst.press(1'b0, HOLD);
        repeat (40) @(posedge clk);
        magnet_operator_inst.press(1'b0, HOLD);
        repeat (8) @(posedge clk);
        check("msg", MSG_ZERO_START, msg);
        n = 0;
        while (msg === MSG_ZERO_START && n < 20000) begin
            @(posedge clk);
            n++;
        end
        check("msg", MSG_ZERO_SET, msg);
        wait_ms(8100);
        check("msg", MSG_READING, msg);
        $display("test zeroing done");
        magnet_operator_inst.press(1'b0, HOLD);
        repeat (40) @(posedge clk);
        magnet_operator_inst.press(1'b1, HOLD);
        repeat (8) @(posedge clk);
        check("msg", MSG_SPAN_START, msg);
        wait_ms(4100);
        check("msg", MSG_READING, msg);
        $display("test span done");
        magnet_operator_inst.press(1'b1, HOLDL);
        repeat (8) @(posedge clk);
        check("msg", MSG_PGM_ITEM, msg);
        check("item", 32'h0, item);
        magnet_operator_inst.press(1'b1, 100);
        repeat (20) @(posedge clk);
        check("item", 32'h1, item);
        wait_ms(7900);
        check("msg", MSG_PGM_ITEM, msg);
        wait_ms(200);
        check("msg", MSG_READING, msg);
        $display("test program done");
        results();
    end
endmodule
